// ===== rtl/smbus_nvm_pkg.sv
// Purpose: Shared constants for the SMBus slave with volatile and paged memory.
// Assumes: 200 MHz ref_clk; memory addresses are offsets from the 8000h base.
// Notes: The timing cycle counts are the defaults of the top-level parameters.
package smbus_nvm_pkg;
  // ****************************************************
  // Addressing and command codes
  // ****************************************************
  localparam int SEL_W = 2;
  localparam logic [4:0] ADDR_FIXED = 5'h0B;
  localparam logic [1:0] ADDR_SEL_OPEN = 2'h2;
  localparam logic [7:0] RAM_LAST = 8'h6F;
  localparam logic [7:0] NVM_HI_FIRST = 8'h80;
  localparam logic [7:0] NVM_HI_LAST = 8'h9F;
  localparam logic [7:0] CMD_BLK_WR = 8'hA0;
  localparam logic [7:0] CMD_BLK_RD = 8'hA1;
  localparam logic [7:0] CMD_NONE = 8'hFF;
  localparam logic [7:0] REG_FACT_A = 8'h06;
  localparam logic [7:0] REG_FACT_B = 8'h0C;
  localparam logic [7:0] REG_MODE = 8'h13;
  // ****************************************************
  // Mode register fields
  // ****************************************************
  localparam int MODE_RD = 0;
  localparam int MODE_PG = 1;
  localparam int MODE_ER = 2;
  localparam int MODE_WP = 3;
  localparam int MODE_STRETCH = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] WP_MASK = 8'h08;
  // ****************************************************
  // Memory geometry
  // ****************************************************
  localparam int RAM_AW = 7;
  localparam int RAM_WORDS = 112;
  localparam int NVM_AW = 13;
  localparam int NVM_BYTES = 8192;
  localparam int NVM_HI_W = 5;
  localparam int PAGE_BITS = 6;
  localparam logic [6:0] USER_PAGES = 7'h7C;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] BLOCK_LEN = 8'h20;
  localparam int FIFO_DEPTH = 16;
  // ****************************************************
  // Byte positions and timing
  // ****************************************************
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_D1 = 6'h01;
  localparam logic [5:0] IDX_D2 = 6'h02;
  localparam logic [5:0] IDX_BLK_LAST = 6'h21;
  localparam logic [5:0] CNT_BLK_LAST = 6'h20;
  localparam logic [5:0] IDX_MAX = 6'h3F;
  localparam int CLK_MHZ = 200;
  localparam int ERASE_TIME_MS = 20;
  localparam int PROG_TIME_US = 250;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
endpackage

// ===== rtl/smbus_nvm_slave.sv
// Purpose: SMBus slave with volatile registers and a paged non-volatile array.
// Assumes: SCL and SDA are open drain, sampled by ref_clk; reset_n is power-on.
// Notes: Programming is queued in a FIFO; a full FIFO stretches SCL or refuses.
// How it works
// - First byte is a seven-bit address, MSB first, then direction bit.
// - On address match the device pulls data low through the ninth clock, except for a memory read outside read mode or during an erase.
// - Nine clocks per byte; data changes only while the clock is low.
// - First byte after a write address is the command byte.
// - Read ends with master not acknowledging, then a stop.
// - A repeated start begins a new operation without a stop.
// - Volatile bytes sit at 00h-6Fh, memory at 8000h-9FFFh.
// - Single bytes and 32-byte blocks move to and from both spaces.
// - Memory has 128 pages of 64 bytes; only erased bytes get programmed.
// - Erase or program of the last four pages is refused.
// - Exactly one of read, program or erase mode bits must be set.
// - Loading a memory address is accepted whatever the mode bits say.
// - Write protect blocks program and erase; set once, cleared by reset.
// - Stretch enable lets the device hold the clock low while busy.
// - A send byte with a volatile command loads the volatile pointer.
// - Command value and mode register pick the write byte/word action.
// - Volatile command with one data byte writes that register.
// - Command 80h-9Fh plus one byte loads the memory address.
// - In erase mode address plus a data byte erases the addressed page.
// - Memory access during a running erase gets no acknowledge.
// - In program mode high, low and data bytes program one byte.
// - Address is 01011 plus two select bits caught at the first start.
// - Command A0h takes a count byte and 32 data bytes from the pointer.
// - Command A1h then repeated start reads count and 32 bytes.
`timescale 1ns/1ps

module nvm_prog_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Depth must be a power of two; the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid & ~full;
  wire pop = out_ready & ~empty;
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module smbus_nvm_slave #(
  parameter int ERASE_CYC = smbus_nvm_pkg::ERASE_CYCLES,
  parameter int PROG_CYC = smbus_nvm_pkg::PROG_CYCLES,
  parameter int FIFO_WORDS = smbus_nvm_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [smbus_nvm_pkg::SEL_W-1:0] addr_sel
);
  import smbus_nvm_pkg::*;

  typedef enum logic [2:0] {st_idle, st_addr, st_write, st_read, st_ignore} bus_state_type;
  localparam int ECW = $clog2(ERASE_CYC + 1);
  localparam int PCW = $clog2(PROG_CYC + 1);
  localparam int FW = NVM_AW + 8;

  function automatic logic one_hot3(input logic [2:0] m);
    return (m == 3'h1) || (m == 3'h2) || (m == 3'h4);
  endfunction

  function automatic logic is_ram(input logic [7:0] b);
    return b <= RAM_LAST;
  endfunction

  function automatic logic is_nvm_hi(input logic [7:0] b);
    return (b >= NVM_HI_FIRST) && (b <= NVM_HI_LAST);
  endfunction

  // ****************************************************
  // Pin sampling
  // ****************************************************
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [SEL_W-1:0] sel_s1;
  logic [SEL_W-1:0] sel_s2;
  logic [SEL_W-1:0] sel_s3;
  logic scl_f;
  logic sda_f;

  // A level counts only once the second and third stages agree
  wire scl_next = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
  wire sda_next = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      sel_s1 <= ADDR_SEL_OPEN;
      sel_s2 <= ADDR_SEL_OPEN;
      sel_s3 <= ADDR_SEL_OPEN;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      sel_s1 <= addr_sel;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      scl_f <= scl_next;
      sda_f <= sda_next;
    end
  end

  wire scl_rise = scl_next & ~scl_f;
  wire scl_fall = ~scl_next & scl_f;
  wire start_det = ~sda_next & sda_f & scl_f & scl_next;
  wire stop_det = sda_next & ~sda_f & scl_f & scl_next;

  // ****************************************************
  // State
  // ****************************************************
  bus_state_type state;
  logic [3:0] bit_cnt;
  logic in_ack;
  logic pending;
  logic rd_go;
  logic sda_low;
  logic scl_low;
  logic [7:0] shift;
  logic [7:0] tx_shift;
  logic [7:0] cmd;
  logic [5:0] byte_idx;
  logic blk_rd;
  logic blk_rd_active;
  logic [5:0] rd_cnt;
  logic [RAM_AW-1:0] ram_ptr;
  logic [NVM_AW-1:0] nvm_ptr;
  logic sel_nvm;
  logic [SEL_W-1:0] dev_sel;
  logic addr_locked;
  logic [7:0] mode;
  logic [7:0] ram [0:RAM_WORDS-1];
  logic [7:0] nvm [0:NVM_BYTES-1];
  logic [ECW-1:0] erase_left;
  logic [PAGE_BITS:0] wipe_idx;
  logic [NVM_AW-PAGE_BITS-1:0] erase_page;
  logic [PCW-1:0] prog_left;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;

  // ****************************************************
  // Byte decode
  // ****************************************************
  wire addr_match = shift[7:1] == {ADDR_FIXED, dev_sel};
  wire dir_read = shift[0];
  wire mode_ok = one_hot3(mode[MODE_ER:MODE_RD]);
  wire rd_mode = mode_ok & mode[MODE_RD];
  wire pg_mode = mode_ok & mode[MODE_PG];
  wire er_mode = mode_ok & mode[MODE_ER];
  wire wp = mode[MODE_WP];
  wire stretch_en = mode[MODE_STRETCH];
  wire erase_busy = erase_left != '0;
  wire cmd_ram = is_ram(cmd);
  wire cmd_nvm = is_nvm_hi(cmd);
  wire cmd_bw = cmd == CMD_BLK_WR;
  wire at_cmd = byte_idx == IDX_CMD;
  wire at_d1 = byte_idx == IDX_D1;
  wire at_d2 = byte_idx == IDX_D2;
  wire in_block = (byte_idx >= IDX_D2) && (byte_idx <= IDX_BLK_LAST);
  wire page_user = nvm_ptr[NVM_AW-1:PAGE_BITS] < USER_PAGES;
  wire nvm_idle = ~erase_busy && (prog_left == '0) && ~fifo_out_valid;
  wire prog_tgt = (cmd_nvm & at_d2) | (cmd_bw & sel_nvm & in_block);
  wire erase_tgt = cmd_nvm & at_d2 & er_mode;
  wire prog_allowed = pg_mode & ~wp & page_user & ~erase_busy;
  wire prog_push_ok = prog_allowed & fifo_in_ready;
  wire erase_ok = er_mode & ~wp & page_user & nvm_idle;
  wire ram_tgt = (cmd_ram & at_d1) | (cmd_bw & ~sel_nvm & in_block);
  wire [RAM_AW-1:0] ram_wr_addr = cmd_bw ? ram_ptr : cmd[RAM_AW-1:0];
  wire extra_nvm = cmd_nvm & (byte_idx > IDX_D2);
  wire wr_ack = prog_tgt ? (erase_tgt ? erase_ok : prog_push_ok) : ~extra_nvm;
  wire in_write = state == st_write;
  // Stretch instead of refusing only when the FIFO alone is in the way
  wire stall = pending & in_write & prog_tgt & ~erase_tgt & prog_allowed &
               ~fifo_in_ready & stretch_en;
  wire proc = pending & ~stall;
  wire fifo_push = proc & in_write & prog_tgt & ~erase_tgt & prog_push_ok;
  wire erase_start = proc & in_write & erase_tgt & erase_ok;
  wire ram_we = proc & in_write & ram_tgt & is_ram({1'b0, ram_wr_addr});
  wire rd_refuse = sel_nvm & (~rd_mode | erase_busy);
  wire addr_ack = addr_match & ~(dir_read & rd_refuse);
  wire active = (state == st_addr) || in_write || (state == st_read);
  wire tx_load = scl_fall & in_ack & (bit_cnt == '0) & (state == st_read) & rd_go;
  wire fact_reg = ({1'b0, ram_ptr} == REG_FACT_A) || ({1'b0, ram_ptr} == REG_FACT_B);
  wire [7:0] ram_rd = ({1'b0, ram_ptr} == REG_MODE) ? mode : fact_reg ? 8'h00 : ram[ram_ptr];
  wire [7:0] rd_data = sel_nvm ? nvm[nvm_ptr] : ram_rd;
  wire blk_count = blk_rd_active & (rd_cnt == '0);
  wire blk_over = blk_rd_active & (rd_cnt > CNT_BLK_LAST);
  wire [7:0] next_tx = blk_count ? BLOCK_LEN : blk_over ? ERASED : rd_data;
  wire tx_data_byte = ~blk_count & ~blk_over;

  // ****************************************************
  // Bus engine
  // ****************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      bit_cnt <= '0;
      in_ack <= 1'b0;
      pending <= 1'b0;
      rd_go <= 1'b0;
      sda_low <= 1'b0;
      shift <= '0;
      tx_shift <= '0;
      byte_idx <= IDX_CMD;
    end else if (start_det) begin
      // Repeated start lands here too and simply reopens the address phase
      state <= st_addr;
      bit_cnt <= '0;
      in_ack <= 1'b0;
      pending <= 1'b0;
      sda_low <= 1'b0;
      byte_idx <= IDX_CMD;
    end else if (stop_det) begin
      state <= st_idle;
      pending <= 1'b0;
      sda_low <= 1'b0;
    end else if (proc) begin
      pending <= 1'b0;
      in_ack <= 1'b1;
      unique case (state)
        st_addr: begin
          sda_low <= addr_ack;
          rd_go <= 1'b1;
          state <= ~addr_ack ? st_ignore : dir_read ? st_read : st_write;
        end
        st_write: begin
          sda_low <= wr_ack;
          if (byte_idx != IDX_MAX) begin
            byte_idx <= byte_idx + 6'h01;
          end
        end
        default: sda_low <= 1'b0;
      endcase
    end else if (scl_rise && active) begin
      if (in_ack) begin
        bit_cnt <= '0;
        rd_go <= ~sda_f;
        if (state == st_read && sda_f) begin
          state <= st_ignore;
        end
      end else begin
        shift <= {shift[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (scl_fall && active) begin
      if (!in_ack && bit_cnt == LAST_BIT) begin
        pending <= 1'b1;
      end else if (in_ack && bit_cnt == '0) begin
        in_ack <= 1'b0;
        sda_low <= tx_load ? ~next_tx[7] : 1'b0;
        if (tx_load) begin
          tx_shift <= next_tx;
        end
      end else if (state == st_read && !in_ack) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
        sda_low <= ~tx_shift[6];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_low <= 1'b0;
      dev_sel <= ADDR_SEL_OPEN;
      addr_locked <= 1'b0;
    end else begin
      // Hold the clock one cycle past the stall so the ack leads the SCL rise
      scl_low <= stall | (scl_low & proc);
      if (!addr_locked && start_det && sel_s2 == sel_s3) begin
        dev_sel <= sel_s3;
        addr_locked <= 1'b1;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_low;
  assign scl_out = 1'b0;
  assign scl_oe_n = ~scl_low;

  // ****************************************************
  // Pointers and commands
  // ****************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= CMD_NONE;
      blk_rd <= 1'b0;
      blk_rd_active <= 1'b0;
      rd_cnt <= '0;
      ram_ptr <= '0;
      nvm_ptr <= '0;
      sel_nvm <= 1'b0;
    end else if (proc && in_write) begin
      if (at_cmd) begin
        cmd <= shift;
        blk_rd <= shift == CMD_BLK_RD;
        if (is_ram(shift)) begin
          ram_ptr <= shift[RAM_AW-1:0];
          sel_nvm <= 1'b0;
        end
      end else if (cmd_nvm && at_d1) begin
        nvm_ptr <= {cmd[NVM_HI_W-1:0], shift};
        sel_nvm <= 1'b1;
      end else if (ram_we && cmd_bw) begin
        ram_ptr <= ram_ptr + 1'b1;
      end else if (fifo_push && cmd_bw) begin
        nvm_ptr <= nvm_ptr + 1'b1;
      end
    end else if (proc && state == st_addr && addr_ack && dir_read) begin
      blk_rd_active <= blk_rd;
      blk_rd <= 1'b0;
      rd_cnt <= '0;
    end else if (tx_load) begin
      if (rd_cnt != IDX_MAX) begin
        rd_cnt <= rd_cnt + 6'h01;
      end
      if (tx_data_byte && sel_nvm) begin
        nvm_ptr <= nvm_ptr + 1'b1;
      end else if (tx_data_byte) begin
        ram_ptr <= ram_ptr + 1'b1;
      end
    end else if (stop_det) begin
      blk_rd <= 1'b0;
    end
  end

  // ****************************************************
  // Volatile space
  // ****************************************************
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      ram[ram_wr_addr] <= shift;
    end
  end

  // Protect bit is kept by OR so software can never clear it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= MODE_RESET;
    end else if (ram_we && {1'b0, ram_wr_addr} == REG_MODE) begin
      mode <= shift | (mode & WP_MASK);
    end
  end

  // ****************************************************
  // Non-volatile array, erase and program sequencing
  // ****************************************************
  wire prog_ready = ~erase_busy & (prog_left == '0);
  wire pop = fifo_out_valid & prog_ready;
  wire [NVM_AW-1:0] pop_addr = fifo_out_data[FW-1:8];
  wire wipe = erase_busy & ~wipe_idx[PAGE_BITS];

  nvm_prog_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({nvm_ptr, shift}),
    .out_valid(fifo_out_valid),
    .out_ready(prog_ready),
    .out_data(fifo_out_data)
  );

  // Contents persist across reset; unwritten cells start unknown
  always_ff @(posedge ref_clk) begin
    if (wipe) begin
      nvm[{erase_page, wipe_idx[PAGE_BITS-1:0]}] <= ERASED;
    end else if (pop && nvm[pop_addr] == ERASED) begin
      nvm[pop_addr] <= fifo_out_data[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_left <= '0;
      wipe_idx <= '0;
      erase_page <= '0;
    end else if (erase_start) begin
      erase_left <= ECW'(ERASE_CYC);
      wipe_idx <= '0;
      erase_page <= nvm_ptr[NVM_AW-1:PAGE_BITS];
    end else if (erase_busy) begin
      erase_left <= erase_left - 1'b1;
      if (wipe) begin
        wipe_idx <= wipe_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_left <= '0;
    end else if (pop) begin
      prog_left <= PCW'(PROG_CYC);
    end else if (prog_left != '0) begin
      prog_left <= prog_left - 1'b1;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_start_opens_addr: assert property (start_det |=> state == st_addr && bit_cnt == '0)
    else $error("start did not open address phase");
  a_read_dir_taken: assert property (proc && state == st_addr && addr_ack && dir_read
    |=> state == st_read)
    else $error("read direction not followed");
  a_addr_ack_held: assert property (proc && state == st_addr && addr_ack
    |=> sda_low && in_ack)
    else $error("matching address not acknowledged");
  a_sda_moves_low: assert property ($changed(sda_low) |-> !scl_f)
    else $error("data line moved while clock high");
  a_foreign_quiet: assert property (state == st_ignore |-> !sda_low && !fifo_push)
    else $error("device active after foreign address");
  a_push_one_mode: assert property (fifo_push |-> mode_ok && mode[MODE_PG])
    else $error("program queued without sole program mode");
  a_wp_blocks: assert property ((fifo_push || erase_start) |-> !mode[MODE_WP])
    else $error("program or erase while protected");
  a_wp_sticky: assert property ($past(mode[MODE_WP]) |-> mode[MODE_WP])
    else $error("write protect cleared");
  a_erase_user: assert property (erase_start |-> page_user)
    else $error("reserved page erased");
  a_erase_refuse: assert property (proc && in_write && prog_tgt && erase_busy
    |=> !sda_low)
    else $error("memory access acked during erase");
  a_stretch_gate: assert property (scl_low |-> stretch_en)
    else $error("clock held without stretch enable");
  a_ram_ptr_load: assert property (proc && in_write && at_cmd && is_ram(shift)
    |=> !sel_nvm && {1'b0, ram_ptr} == $past(shift))
    else $error("send byte did not load pointer");

  c_read_start: cover property (proc && state == st_addr && addr_ack && dir_read);
  c_erase_run: cover property (erase_start ##1 erase_busy [*8]);
  c_stall_seen: cover property (stall ##1 scl_low);
  c_block_read: cover property (tx_load && blk_rd_active && rd_cnt == CNT_BLK_LAST);
endmodule

// ===== tb/smbus_master_model.sv
// Purpose: Bus master that drives SCL and SDA for the slave bench.
// Assumes: The bench resolves the wires; a 1 on scl_m or sda_m releases a line.
// Notes: A quarter bit is 4 ref_clk, so SCL runs at 80 ns and rests between frames.
`timescale 1ns/1ps
module smbus_master_model (
  input wire logic ref_clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_m = 1'b1,
  output logic sda_m = 1'b1
);
  task automatic q();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // The slave may hold SCL low while busy, so wait on the wire, bounded
  task automatic hi();
    scl_m = 1'b1;
    for (int i = 0; i < 5000 && !scl_w; i++) @(posedge ref_clk);
  endtask
  task automatic start();
    sda_m = 1'b1;
    q();
    hi();
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    q();
    hi();
    q();
    sda_m = 1'b1;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    q();
    hi();
    q();
    r = sda_w;
    q();
    scl_m = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~ack, r);
  endtask
endmodule

// ===== tb/smbus_nvm_slave_tb.sv
// Purpose: Self-checking bench for the SMBus slave with paged memory.
// Assumes: Open address strap, so the slave answers at 5Ch; short erase and program.
// Notes: Write protect comes last because only a reset clears it.
`timescale 1ns/1ps
module smbus_nvm_slave_tb;
  import smbus_nvm_pkg::*;
  localparam logic [7:0] AW = {ADDR_FIXED, ADDR_SEL_OPEN, 1'b0};
  logic ref_clk;
  logic reset_n = 1'b0;
  logic [1:0] addr_sel = ADDR_SEL_OPEN;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m, a;
  logic [63:0] k;
  logic [7:0] d[$];
  int err_total, checked, cyc;
  wire scl_w = scl_m & (scl_oe_n ? 1'b1 : scl_out);
  wire sda_w = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  smbus_nvm_slave #(.ERASE_CYC(1000), .PROG_CYC(400), .FIFO_WORDS(16)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel));
  smbus_master_model m (.ref_clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // First byte of b is the address byte; k collects one ack bit per byte
  task automatic wr(input logic [7:0] b[$], input bit rs, output logic [63:0] ak);
    logic x;
    ak = '0;
    m.start();
    foreach (b[i]) begin
      m.wbyte(b[i], x);
      ak[i] = x;
    end
    if (!rs) m.stop();
  endtask
  task automatic rq(input logic [7:0] b[$], input int n);
    logic [7:0] v;
    wr(b, 1, k);
    d = {};
    m.start();
    m.wbyte(AW | 8'h01, a);
    for (int i = 0; i < n && a; i++) begin
      m.rbyte(i < n - 1, v);
      d.push_back(v);
    end
    m.stop();
  endtask
  task automatic t_ram();
    wr('{AW | 8'h02, 8'h20}, 0, k);
    chk("foreign", k, 64'h0);
    // Strap moves after the lock; the slave must keep its first address
    addr_sel = 2'h0;
    wr('{AW, 8'h20, 8'h5A}, 0, k);
    chk("ram_wr", k, 64'h7);
    rq('{AW, 8'h20}, 1);
    chk("ram_rd", d[0], 8'h5A);
    rq('{AW, REG_MODE}, 1);
    chk("mode_rst", d[0], MODE_RESET);
    wr('{AW, REG_FACT_A, 8'h55}, 0, k);
    rq('{AW, REG_FACT_A}, 1);
    chk("fact_rd", d[0], 8'h00);
    addr_sel = ADDR_SEL_OPEN;
    $display("done ram");
  endtask
  task automatic t_nvm();
    wr('{AW, REG_MODE, 8'h04}, 0, k);
    wr('{AW, 8'h80, 8'h40, 8'hEE}, 0, k);
    chk("erase", k, 64'hF);
    wr('{AW, 8'h80, 8'h40, 8'hEE}, 0, k);
    chk("erase_busy", k, 64'h7);
    repeat (1000) @(posedge ref_clk);
    wr('{AW, 8'h9F, 8'h00, 8'h00}, 0, k);
    chk("last_pages", k, 64'h7);
    wr('{AW, REG_MODE, 8'h82}, 0, k);
    wr('{AW, 8'h80, 8'h41, 8'hA5}, 0, k);
    chk("program", k, 64'hF);
    repeat (600) @(posedge ref_clk);
    wr('{AW, 8'h80, 8'h41, 8'h3C}, 0, k);
    chk("reprog", k, 64'hF);
    repeat (600) @(posedge ref_clk);
    wr('{AW, REG_MODE, 8'h03}, 0, k);
    rq('{AW, 8'h80, 8'h40}, 1);
    chk("bad_mode", {k[3:0], 3'h0, a}, 12'h070);
    wr('{AW, REG_MODE, 8'h01}, 0, k);
    rq('{AW, 8'h80, 8'h40}, 2);
    chk("nvm_rd", {d[0], d[1]}, 16'hFFA5);
    $display("done nvm");
  endtask
  task automatic t_blk();
    logic [7:0] b[$];
    b = '{AW, CMD_BLK_WR, BLOCK_LEN};
    for (int i = 0; i < 32; i++) b.push_back(8'h40 + 8'(i));
    wr('{AW, REG_MODE, 8'h04}, 0, k);
    wr('{AW, 8'h80, 8'h80, 8'h00}, 0, k);
    repeat (1000) @(posedge ref_clk);
    wr('{AW, REG_MODE, 8'h82}, 0, k);
    wr('{AW, 8'h80, 8'h80}, 0, k);
    wr(b, 0, k);
    chk("blk_wr", k, 64'h7FFFFFFFF);
    repeat (7000) @(posedge ref_clk);
    wr('{AW, REG_MODE, 8'h01}, 0, k);
    wr('{AW, 8'h80, 8'h80}, 0, k);
    rq('{AW, CMD_BLK_RD}, 33);
    chk("blk_cnt", d[0], BLOCK_LEN);
    for (int i = 0; i < 32; i++) chk("blk_rd", d[i + 1], 8'h40 + 8'(i));
    wr('{AW, REG_MODE, 8'h02}, 0, k);
    wr('{AW, 8'h80, 8'h80}, 0, k);
    wr(b, 0, k);
    chk("full_nack", &k[34:0], 1'b0);
    repeat (7000) @(posedge ref_clk);
    $display("done block");
  endtask
  task automatic t_wp();
    wr('{AW, REG_MODE, 8'h0A}, 0, k);
    wr('{AW, 8'h80, 8'h42, 8'h11}, 0, k);
    chk("wp_prog", k, 64'h7);
    wr('{AW, REG_MODE, 8'h00}, 0, k);
    rq('{AW, REG_MODE}, 1);
    chk("wp_sticky", d[0], WP_MASK);
    reset_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    rq('{AW, REG_MODE}, 1);
    chk("wp_reset", d[0], MODE_RESET);
    $display("done protect");
  endtask
  task automatic give_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_ram();
    t_nvm();
    t_blk();
    t_wp();
    give_verdict();
  end
endmodule
